/* include/mef_map.vh */
`ifndef MEF_MAP_VH
`define MEF_MAP_VH
// message information word bit positions
`define MEF_BIT_ROLLOVER 7
`define MEF_BIT_STATUS_FLAG 6
`define MEF_BIT_LENGTH 5
`define MEF_BIT_SYNC_TYPE 4
`define MEF_BIT_INVALID_WORD 3
`define MEF_BIT_PAIR_GAP 2
`define MEF_BIT_PAIR_CMD2 1
`define MEF_BIT_CMD_CONTENT 0
`define MEF_BIT_TIMEOUT 9
`define MEF_BIT_PAIR 11
`define MEF_BIT_SUMMARY 12
`define MEF_INFO_RESET 16'h0000
// register offsets
`define MEF_REG_CONFIG 4'h0
`define MEF_REG_INFO 4'h1
`define MEF_REG_LAST 4'h2
// configuration bits
`define MEF_CFG_GAP_EN 12
`define MEF_CFG_RESET 16'h0000
// command word fields
`define MEF_CW_TR 10
`define MEF_BCAST_ADDR 5'h1f
// gap limit, ns, and clock period
`define MEF_GAP_MIN_NS 4000
`define MEF_CLK_NS 20
`define MEF_GAP_MIN_CYC ((`MEF_GAP_MIN_NS + `MEF_CLK_NS - 1) / `MEF_CLK_NS)
`endif

/* hdl/mef_flags.v */
// Functional notes
// - set bit 7 when record storage wrapped past buffer end to base.
// - set bit 6 when any RT status word without invalid or sync fault has a status flag bit set.
// - set bit 5 when data word count differs from commanded count.
// - busy bit in status word suppresses the length error.
// - transmit command with response timeout suppresses the length error.
// - set bit 4 on wrong sync type for command, data or status word.
// - set bit 3 on invalid word: manchester, bit count or parity fault.
// - gap check enabled: set bit 2 when RT-RT status response under 4 us.
// - RT-RT: set bit 2 when either status word is invalid.
// - RT-RT: set bit 2 when status address differs from its command address.
// - RT-RT: set bit 1 when second command has T/R bit zero.
// - RT-RT: set bit 1 when second command subaddress is 0 or 31.
// - RT-RT: set bit 1 when second command repeats first command address.
// - RT-RT: set bit 1 when second command has a sync error.
// - set bit 0 on broadcast transmit non-mode command, subaddress 1 to 30.
// - set bit 0 on receive mode code command with code 0 to 15.
// - set bit 0 on broadcast transmit mode code 0, 2, 16, 18 or 19.
// - bit 12 summarises bits 5..0 except the three quiet cases.
// - set bit 9 when an RT status word misses the response timeout.
`timescale 1ns/1ps
`include "mef_map.vh"
module mef_flags #(
	parameter GAP_MIN_CYC = `MEF_GAP_MIN_CYC
) (
	input wire ref_clk,
	input wire rst,
	// decoded word stream from the bus decoder
	input wire msg_start,
	input wire msg_end,
	input wire word_valid,
	input wire [15:0] word_data,
	input wire word_cmd_sync,
	input wire word_is_cmd,
	input wire word_is_status,
	input wire word_is_data,
	input wire word_invalid,
	input wire word_sync_err,
	input wire resp_timeout,
	input wire buf_rollover,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// record write of finished information word
	output reg info_wr,
	output reg [15:0] info_word
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_CMD1 = 4'b0010;
	localparam ST_RESP = 4'b0100;
	localparam ST_DATA = 4'b1000;

	reg [3:0] state_r;
	reg [15:0] cfg_r;
	reg [15:0] flags_r;
	reg [15:0] flags_nxt;
	reg [15:0] cmd1_r;
	reg [15:0] cmd2_r;
	reg pair_r;
	reg [5:0] data_cnt_r;
	reg [5:0] exp_cnt_r;
	reg status_cnt_r;
	reg busy_seen_r;
	reg xmit_cmd_r;
	reg [15:0] gap_cnt_r;
	reg quiet_r;
	reg [1:0] status_seen_r;

	// commanded word count, 0 means 32; mode codes carry no more than one word
	function [5:0] word_count;
		input [15:0] cw;
		begin
			if (cw[9:5] == 5'h00 || cw[9:5] == 5'h1f)
				word_count = {5'h00, cw[4]};
			else if (cw[4:0] == 5'h00)
				word_count = 6'h20;
			else
				word_count = {1'b0, cw[4:0]};
		end
	endfunction

	function is_mode;
		input [15:0] cw;
		begin
			is_mode = (cw[9:5] == 5'h00) || (cw[9:5] == 5'h1f);
		end
	endfunction

	function cmd_content_err;
		input [15:0] cw;
		reg bc;
		reg tx;
		begin
			bc = (cw[15:11] == `MEF_BCAST_ADDR);
			tx = cw[`MEF_CW_TR];
			cmd_content_err = (bc && tx && !is_mode(cw)) ||
				(bc && tx && is_mode(cw) && (cw[4:0] == 5'd0 || cw[4:0] == 5'd2 ||
				cw[4:0] == 5'd16 || cw[4:0] == 5'd18 || cw[4:0] == 5'd19));
		end
	endfunction

	function rx_mode_undef;
		input [15:0] cw;
		begin
			rx_mode_undef = !cw[`MEF_CW_TR] && is_mode(cw) && !cw[4];
		end
	endfunction

	wire gap_en = cfg_r[`MEF_CFG_GAP_EN];
	wire word_bad = word_invalid || word_sync_err;
	// a status word expected on this word: data sync where a status stands is a sync fault
	wire sync_wrong = (word_is_cmd || word_is_status) ? !word_cmd_sync : word_cmd_sync;

	always @* begin
		flags_nxt = flags_r;
		if (buf_rollover)
			flags_nxt[`MEF_BIT_ROLLOVER] = 1'b1;
		if (resp_timeout && state_r != ST_IDLE)
			flags_nxt[`MEF_BIT_TIMEOUT] = 1'b1;
		if (word_valid && state_r != ST_IDLE) begin
			if (word_invalid)
				flags_nxt[`MEF_BIT_INVALID_WORD] = 1'b1;
			if (word_sync_err || sync_wrong)
				flags_nxt[`MEF_BIT_SYNC_TYPE] = 1'b1;
			if (word_is_status && !word_bad && (word_data[10:0] & 11'h5ff) != 11'h000)
				flags_nxt[`MEF_BIT_STATUS_FLAG] = 1'b1;
			if (state_r == ST_CMD1 && word_is_cmd) begin
				flags_nxt[`MEF_BIT_PAIR] = 1'b1;
				if (!word_data[`MEF_CW_TR] || word_sync_err)
					flags_nxt[`MEF_BIT_PAIR_CMD2] = 1'b1;
				if (is_mode(word_data) || word_data[15:11] == cmd1_r[15:11])
					flags_nxt[`MEF_BIT_PAIR_CMD2] = 1'b1;
			end
			if (pair_r && word_is_status) begin
				if (word_bad)
					flags_nxt[`MEF_BIT_PAIR_GAP] = 1'b1;
				if (word_data[15:11] != (status_cnt_r ? cmd1_r[15:11] : cmd2_r[15:11]))
					flags_nxt[`MEF_BIT_PAIR_GAP] = 1'b1;
				if (gap_en && gap_cnt_r < GAP_MIN_CYC)
					flags_nxt[`MEF_BIT_PAIR_GAP] = 1'b1;
			end
		end
	end

	// summary counts all of 5..0 except the quiet cmd2/mode cases
	wire loud_err = (|flags_r[5:2]) || ((|flags_r[1:0]) && !quiet_r);
	// length mismatch, excused by busy and by a timed-out transmit
	wire len_err = (data_cnt_r != exp_cnt_r) && !busy_seen_r &&
		!(xmit_cmd_r && flags_r[`MEF_BIT_TIMEOUT]);

	always @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cfg_r <= `MEF_CFG_RESET;
			flags_r <= `MEF_INFO_RESET;
			cmd1_r <= 16'h0000;
			cmd2_r <= 16'h0000;
			pair_r <= 1'b0;
			data_cnt_r <= 6'h00;
			exp_cnt_r <= 6'h00;
			status_cnt_r <= 1'b0;
			busy_seen_r <= 1'b0;
			xmit_cmd_r <= 1'b0;
			gap_cnt_r <= 16'h0000;
			quiet_r <= 1'b0;
			status_seen_r <= 2'b00;
			info_wr <= 1'b0;
			info_word <= `MEF_INFO_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			info_wr <= 1'b0;
			if (reg_wr && reg_addr == `MEF_REG_CONFIG)
				cfg_r <= reg_wdata;
			if (reg_rd) begin
				case (reg_addr)
					`MEF_REG_CONFIG: reg_rdata <= cfg_r;
					`MEF_REG_INFO: reg_rdata <= flags_r;
					`MEF_REG_LAST: reg_rdata <= info_word;
					default: reg_rdata <= 16'h0000;
				endcase
			end
			// gap counter restarts on every word end; saturates
			if (word_valid)
				gap_cnt_r <= 16'h0000;
			else if (gap_cnt_r != 16'hffff)
				gap_cnt_r <= gap_cnt_r + 16'h0001;
			if (msg_start) begin
				state_r <= ST_CMD1;
				flags_r <= `MEF_INFO_RESET;
				if (buf_rollover)
					flags_r[`MEF_BIT_ROLLOVER] <= 1'b1;
				cmd1_r <= word_data;
				pair_r <= 1'b0;
				data_cnt_r <= 6'h00;
				exp_cnt_r <= word_count(word_data);
				status_cnt_r <= 1'b0;
				busy_seen_r <= 1'b0;
				xmit_cmd_r <= word_data[`MEF_CW_TR];
				status_seen_r <= 2'b00;
				flags_r[`MEF_BIT_CMD_CONTENT] <= cmd_content_err(word_data) ||
					rx_mode_undef(word_data);
				flags_r[`MEF_BIT_SYNC_TYPE] <= !word_cmd_sync || word_sync_err;
				flags_r[`MEF_BIT_INVALID_WORD] <= word_invalid;
				quiet_r <= rx_mode_undef(word_data) && !cmd_content_err(word_data);
			end else if (msg_end && state_r != ST_IDLE) begin
				// close the record: fold in length and summary
				state_r <= ST_IDLE;
				info_wr <= 1'b1;
				info_word <= flags_nxt | ({15'h0000, len_err} << `MEF_BIT_LENGTH) |
					({15'h0000, loud_err || len_err} << `MEF_BIT_SUMMARY);
				flags_r <= flags_nxt;
			end else begin
				flags_r <= flags_nxt;
				case (state_r)
					ST_IDLE: begin
					end
					ST_CMD1: begin
						if (word_valid && word_is_cmd) begin
							pair_r <= 1'b1;
							cmd2_r <= word_data;
							xmit_cmd_r <= 1'b1;
							// quiet only when cmd2 fault is address or mode alone
							if (!word_data[`MEF_CW_TR] || word_sync_err)
								quiet_r <= 1'b0;
							else if (is_mode(word_data) || word_data[15:11] == cmd1_r[15:11])
								quiet_r <= !flags_r[`MEF_BIT_CMD_CONTENT] || quiet_r;
							state_r <= ST_RESP;
						end else if (word_valid) begin
							state_r <= ST_DATA;
						end
						if (word_valid && word_is_data)
							data_cnt_r <= data_cnt_r + 6'h01;
						if (word_valid && word_is_status) begin
							status_seen_r <= status_seen_r + 2'b01;
							busy_seen_r <= busy_seen_r || word_data[3];
						end
					end
					ST_RESP, ST_DATA: begin
						if (word_valid && word_is_data && data_cnt_r != 6'h3f)
							data_cnt_r <= data_cnt_r + 6'h01;
						if (word_valid && word_is_status) begin
							status_cnt_r <= 1'b1;
							status_seen_r <= status_seen_r + 2'b01;
							busy_seen_r <= busy_seen_r || word_data[3];
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

/* verif/mef_flags_props.sv */
`timescale 1ns/1ps
`include "mef_map.vh"
module mef_flags_chk #(
	parameter GAP_MIN_CYC = 200
) (
	input wire ref_clk,
	input wire rst,
	input wire msg_start,
	input wire msg_end,
	input wire resp_timeout,
	input wire buf_rollover,
	input wire [3:0] reg_addr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire info_wr,
	input wire [15:0] info_word
);
	logic open_r, roll_r, tmo_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// set beats clear, so an event in the start cycle belongs to the new message
	always @(posedge ref_clk) begin
		open_r <= !rst && (msg_start || (open_r && !msg_end));
		roll_r <= !rst && (buf_rollover || (roll_r && !msg_start));
		tmo_r <= !rst && (resp_timeout || (tmo_r && !msg_start));
	end
	sequence s_close;
		open_r && msg_end;
	endsequence
	sequence s_write;
		info_wr ##1 !info_wr;
	endsequence
	AST_CLOSE: assert property (s_close |=> s_write) else $error("no single record write");
	AST_CAUSE: assert property (info_wr |-> $past(msg_end)) else $error("stray record write");
	AST_HOLD: assert property (!info_wr |-> $stable(info_word)) else $error("word moved");
	AST_ROLL: assert property (info_wr |-> info_word[`MEF_BIT_ROLLOVER] == roll_r)
		else $error("rollover flag wrong");
	AST_TMO: assert property (info_wr |-> info_word[`MEF_BIT_TIMEOUT] == tmo_r)
		else $error("timeout flag wrong");
	AST_SUM: assert property (info_wr && info_word[5:2] != 4'h0 |-> info_word[`MEF_BIT_SUMMARY])
		else $error("summary missing");
	AST_SUMOFF: assert property (info_wr && info_word[5:0] == 6'h00 |-> !info_word[12])
		else $error("summary without cause");
	AST_UNMAP: assert property (reg_rd && reg_addr > 4'h2 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RDHOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule
bind mef_flags mef_flags_chk #(.GAP_MIN_CYC(GAP_MIN_CYC)) u_chk (.*);

/* verif/mef_bus_model.sv */
`timescale 1ns/1ps
module mef_bus_model (
	input wire ref_clk,
	output logic msg_start,
	output logic msg_end,
	output logic word_valid,
	output logic [15:0] word_data,
	output logic word_cmd_sync,
	output logic word_is_cmd,
	output logic word_is_status,
	output logic word_is_data,
	output logic word_invalid,
	output logic word_sync_err,
	output logic resp_timeout,
	output logic buf_rollover
);
	initial begin
		{msg_start, msg_end, word_valid, word_cmd_sync, word_is_cmd, word_is_status} = '0;
		{word_is_data, word_invalid, word_sync_err, resp_timeout, buf_rollover} = '0;
		word_data = 16'h0000;
	end
	// k: 0 command, 1 status, 2 data, 3 start, 4 end, 5 timeout, 6 rollover
	// e: sync type flipped, invalid word, sync fault
	task automatic ev(input int k, input [15:0] d, input [2:0] e);
		@(posedge ref_clk);
		msg_start <= k == 3;
		msg_end <= k == 4;
		resp_timeout <= k == 5;
		buf_rollover <= k == 6;
		word_valid <= k < 3;
		word_is_cmd <= k == 0;
		word_is_status <= k == 1;
		word_is_data <= k == 2;
		word_data <= d;
		word_cmd_sync <= (k != 2) ^ e[0];
		word_invalid <= e[1];
		word_sync_err <= e[2];
		@(posedge ref_clk);
		{msg_start, msg_end, word_valid, word_is_cmd, word_is_status, word_is_data} <= '0;
		{word_invalid, word_sync_err, resp_timeout, buf_rollover} <= '0;
		// a released line must not keep showing the last word
		word_data <= ~d;
	endtask
endmodule

/* verif/tb_mef_flags.sv */
`timescale 1ns/1ps
module tb_mef_flags;
	logic ref_clk = 0;
	logic rst = 1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	wire [15:0] reg_rdata, info_word, word_data;
	wire info_wr, msg_start, msg_end, word_valid, word_cmd_sync, word_is_cmd, word_is_status;
	wire word_is_data, word_invalid, word_sync_err, resp_timeout, buf_rollover;
	int mismatches = 0;
	int num_checks = 0;
	int a, i, k;
	int bm[5] = '{0, 2, 16, 18, 19};
	int sa[6];
	logic [15:0] c2[6];
	logic [15:0] ex[6];
	logic [2:0] ce[6];
	initial forever #10 ref_clk = ~ref_clk;
	mef_bus_model u_bus (.*);
	mef_flags #(.GAP_MIN_CYC(20)) dut_u (.*);
	function automatic [15:0] cw(input int r, t, s, w);
		cw = {r[4:0], t[0], s[4:0], w[4:0]};
	endfunction
	task automatic check(input [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input [3:0] ad, input [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 check(reg_rdata, e);
	endtask
	task automatic done(input [15:0] e);
		int n;
		u_bus.ev(4, 16'h0000, 3'h0);
		for (n = 0; n < 4; n++) begin
			@(negedge ref_clk);
			if (info_wr === 1'b1) break;
		end
		if (n == 4) begin
			mismatches++;
			// a record that never closes abandons the sequence for the report
			disable main.body;
		end
		check(info_word, e);
	endtask
	initial begin : main
		void'($urandom(32'h361e8090));
		begin : body
		repeat (5) @(posedge ref_clk);
		rst <= 0;
		a = $urandom_range(1, 28);
		rd(4'h0, 16'h0000);
		rd(4'hf, 16'h0000);
		for (k = 2; k >= 1; k--) begin
			u_bus.ev(3, cw(a, 0, 1, 2), 3'h0);
			if (k == 1) u_bus.ev(6, 16'h0000, 3'h0);
			u_bus.ev(1, {a[4:0], 11'h000}, 3'h0);
			repeat (k) u_bus.ev(2, 16'($urandom), 3'h0);
			done(k == 2 ? 16'h0000 : 16'h10a0);
		end
		rd(4'h2, 16'h10a0);
		u_bus.ev(3, cw(a, 1, 1, 3), 3'h0);
		u_bus.ev(1, {a[4:0], 11'h008}, 3'h0);
		done(16'h0040);
		u_bus.ev(3, cw(a, 1, 1, 3), 3'h0);
		u_bus.ev(5, 16'h0000, 3'h0);
		done(16'h0200);
		u_bus.ev(3, cw(a, 0, 1, 2), 3'h0);
		u_bus.ev(1, {a[4:0], 11'h000}, 3'h3);
		rd(4'h1, 16'h0018);
		repeat (2) u_bus.ev(2, 16'($urandom), 3'h0);
		done(16'h1018);
		u_bus.ev(3, cw(a, 0, 0, $urandom_range(0, 15)), 3'h0);
		u_bus.ev(1, {a[4:0], 11'h000}, 3'h0);
		done(16'h0001);
		foreach (bm[i]) begin
			u_bus.ev(3, cw(31, 1, 0, bm[i]), 3'h0);
			// codes from 16 up command one data word that never comes
			done(bm[i] >= 16 ? 16'h1021 : 16'h1001);
		end
		c2 = '{cw(a, 1, 2, 1), cw(a + 1, 0, 2, 1), cw(a + 1, 1, 31, 1), cw(a + 1, 1, 2, 1),
			cw(a + 1, 1, 2, 1), cw(a + 1, 1, 2, 1)};
		ce = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0};
		sa = '{a, a, a, a, a + 2, a};
		// a sync fault on the second command also counts as a sync type fault
		ex = '{16'h0802, 16'h1802, 16'h0802, 16'h1812, 16'h1804, 16'h1804};
		for (i = 0; i < 6; i++) begin
			if (i == 5) begin
				@(posedge ref_clk);
				reg_wr <= 1;
				reg_wdata <= 16'h1000;
				reg_addr <= 4'h0;
				@(posedge ref_clk);
				reg_wr <= 0;
			end
			u_bus.ev(3, cw(a, 0, 1, 1), 3'h0);
			u_bus.ev(0, c2[i], ce[i]);
			u_bus.ev(1, {c2[i][15:11], 11'h000}, 3'h0);
			u_bus.ev(2, 16'($urandom), 3'h0);
			u_bus.ev(1, 16'(sa[i] << 11), 3'h0);
			done(ex[i]);
		end
		rd(4'h0, 16'h1000);
		end
		print_verdict();
	end
endmodule
